// >>> ssp_core.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "ssp_defs.svh"

// ==========================================================================
// Word FIFO shared by the transmit and receive paths.
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             push_valid,
  output logic                  push_ready,
  input  wire logic [WIDTH-1:0] push_data,
  // Drain side
  output logic                  pop_valid,
  input  wire logic             pop_ready,
  output logic [WIDTH-1:0]      pop_data,
  output logic [AW:0]           level
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      level_r, level_nxt;
  logic             do_push, do_pop;

  always_comb begin
    push_ready = (level_r != (AW+1)'(DEPTH));
    pop_valid  = (level_r != '0);
    do_push    = push_valid & push_ready;
    do_pop     = pop_valid & pop_ready;
    wr_nxt     = do_push ? ((wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1) : wr_r;
    rd_nxt     = do_pop ? ((rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1) : rd_r;
    level_nxt  = level_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_r    <= '0;
      rd_r    <= '0;
      level_r <= '0;
    end else begin
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      level_r <= level_nxt;
    end
    if (do_push) begin
      mem_r[wr_r] <= push_data;
    end
  end

  assign pop_data = mem_r[rd_r];
  assign level    = level_r;
endmodule

// ==========================================================================
// Synchronous serial port core.
module ssp_core #(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Register bus
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Serial pins
  output logic             serial_clock_out,
  output logic             serial_clock_oe,
  input  wire logic        serial_clock_in,
  output logic             frame_select_out,
  output logic             frame_select_oe,
  input  wire logic        frame_select_in,
  output logic             serial_transmit_line,
  output logic             serial_transmit_oe,
  input  wire logic        serial_receive_line,
  // Interrupts
  output logic             irq,
  output logic             irq_tx,
  output logic             irq_rx,
  output logic             irq_timeout,
  output logic             irq_overrun
);
  import ssp_pkg::*;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic              ack_r, ack_nxt, pop_ok_r, pop_ok_nxt, rt_r, rt_nxt, ror_r, ror_nxt;
  logic [31:0]       readdata_r, readdata_nxt;
  logic [15:0]       ctrl0_r, ctrl0_nxt, lane_m;
  logic [2:0]        ctrl1_r, ctrl1_nxt;
  logic [7:0]        prescale_r, prescale_nxt;
  logic [3:0]        imask_r, imask_nxt, irqv_r, irqv_nxt, ris;
  logic              acc, wr_en, rd_commit, tx_push, rx_pop;
  logic              sclk_s1, sclk_s2, sclk_s3, fss_s1, fss_s2, fss_s3, rxd_s1, rxd_s2;
  logic [6:0]        pre_cnt_r, pre_cnt_nxt, half_pre;
  logic [7:0]        scr_cnt_r, scr_cnt_nxt;
  logic              half_tick, tick;
  eng_state_t        st_r, st_nxt;
  logic [15:0]       sh_r, sh_nxt, rx_sh_r, rx_sh_nxt, sh_load, rx_word;
  logic [5:0]        edge_r, edge_nxt, edge_inc, fbits, edges_tot;
  logic [4:0]        nbits;
  logic [1:0]        lead_r, lead_nxt;
  logic              sclk_r, sclk_nxt, fss_r, fss_nxt, txd_r, txd_nxt;
  logic [6:0]        rt_cnt_r, rt_cnt_nxt;
  logic              load, rx_push, rt_evt, ror_evt, go, slv_go, slv_ssf, fss_lost, ph1, rxd_in;
  logic              en, slave, loopback, cpol;
  frame_fmt_t        fmt;
  logic              tx_ready, tx_valid, rx_ready, rx_valid;
  logic [DATA_W-1:0] tx_head, rx_head;
  logic [LW-1:0]     tx_level, rx_level;

  // ==========================================================================
  // Configuration decode.
  assign en       = ctrl1_r[`C1_EN];
  assign slave    = ctrl1_r[`C1_SLAVE];
  assign loopback = ctrl1_r[`C1_LOOP];
  assign fmt      = frame_fmt_t'(ctrl0_r[5:4]);
  assign cpol     = (fmt == FMT_SPI) & ctrl0_r[`C0_CPOL];
  assign ph1      = (fmt == FMT_SPI) ? ctrl0_r[`C0_CPHA] : (fmt == FMT_SSF);
  // Sizes below four bits cannot be framed, so they run as four.
  assign nbits    = (ctrl0_r[3:0] < 4'd3) ? `MIN_BITS : {1'b0, ctrl0_r[3:0]} + 5'd1;
  assign fbits    = (fmt == FMT_CR) ? {1'b0, nbits} + `CR_EXTRA_BITS : {1'b0, nbits};
  assign edges_tot = {fbits[4:0], 1'b0};
  // The command format sends only the low byte, then receives the reply.
  assign sh_load  = (fmt == FMT_CR) ? {tx_head[7:0], 8'h00} : tx_head << (5'd16 - nbits);
  assign rx_word  = rx_sh_nxt & (16'hffff >> (5'd16 - nbits));

  // ==========================================================================
  // Register bus slave: every access stalls exactly one cycle.
  assign acc         = read | write;
  assign waitrequest = acc & ~ack_r;
  assign wr_en       = write & ack_r;
  assign rd_commit   = read & ack_r;
  assign lane_m      = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign tx_push     = wr_en & (address == `OFS_DATA) & (|byteenable[1:0]);
  assign rx_pop      = rd_commit & (address == `OFS_DATA) & pop_ok_r;
  assign ris         = {ror_r, rt_r, (rx_level >= LW'(FIFO_DEPTH / 2)),
                        (tx_level <= LW'(FIFO_DEPTH / 2))};

  always_comb begin
    ack_nxt      = acc & ~ack_r;
    readdata_nxt = readdata_r;
    pop_ok_nxt   = pop_ok_r;
    ctrl0_nxt    = ctrl0_r;
    ctrl1_nxt    = ctrl1_r;
    prescale_nxt = prescale_r;
    imask_nxt    = imask_r;
    rt_nxt       = rt_r | rt_evt;
    ror_nxt      = ror_r | ror_evt;
    if (acc && !ack_r && read) begin
      pop_ok_nxt = (address == `OFS_DATA) && rx_valid;
      case (address)
        `OFS_CTRL0:    readdata_nxt = {16'h0000, ctrl0_r};
        `OFS_CTRL1:    readdata_nxt = {29'h0, ctrl1_r};
        `OFS_DATA:     readdata_nxt = rx_valid ? {16'h0000, rx_head} : 32'h0;
        `OFS_STATUS:   readdata_nxt = {27'h0, (st_r != ST_IDLE), ~rx_ready, rx_valid, tx_ready, ~tx_valid};
        `OFS_PRESCALE: readdata_nxt = {24'h0, prescale_r};
        `OFS_IMASK:    readdata_nxt = {28'h0, imask_r};
        `OFS_RIS:      readdata_nxt = {28'h0, ris};
        `OFS_MIS:      readdata_nxt = {28'h0, ris & imask_r};
        default:       readdata_nxt = 32'h0;
      endcase
    end
    if (wr_en) begin
      case (address)
        `OFS_CTRL0:    ctrl0_nxt = (ctrl0_r & ~lane_m) | (writedata[15:0] & lane_m);
        `OFS_CTRL1:    if (byteenable[0]) ctrl1_nxt = writedata[2:0];
        `OFS_PRESCALE: if (byteenable[0]) prescale_nxt = {writedata[7:1], 1'b0};
        `OFS_IMASK:    if (byteenable[0]) imask_nxt = writedata[3:0];
        `OFS_ICLR: begin
          if (byteenable[0]) begin
            // A new event in the clearing cycle keeps its flag set.
            rt_nxt  = rt_evt | (rt_r & ~writedata[`INT_RT]);
            ror_nxt = ror_evt | (ror_r & ~writedata[`INT_ROR]);
          end
        end
        default: ;
      endcase
    end
    irqv_nxt = ris & imask_r;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0;
      pop_ok_r   <= 1'b0;
      ctrl0_r    <= `CTRL0_RST;
      ctrl1_r    <= 3'h0;
      prescale_r <= `PRESCALE_RST;
      imask_r    <= 4'h0;
      rt_r       <= 1'b0;
      ror_r      <= 1'b0;
      irqv_r     <= 4'h0;
    end else begin
      ack_r      <= ack_nxt;
      readdata_r <= readdata_nxt;
      pop_ok_r   <= pop_ok_nxt;
      ctrl0_r    <= ctrl0_nxt;
      ctrl1_r    <= ctrl1_nxt;
      prescale_r <= prescale_nxt;
      imask_r    <= imask_nxt;
      rt_r       <= rt_nxt;
      ror_r      <= ror_nxt;
      irqv_r     <= irqv_nxt;
    end
  end

  assign readdata    = readdata_r;
  assign irq_tx      = irqv_r[`INT_TX];
  assign irq_rx      = irqv_r[`INT_RX];
  assign irq_timeout = irqv_r[`INT_RT];
  assign irq_overrun = irqv_r[`INT_ROR];
  assign irq         = |irqv_r;

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .push_valid (tx_push),
    .push_ready (tx_ready),
    .push_data  (writedata[DATA_W-1:0]),
    .pop_valid  (tx_valid),
    .pop_ready  (load),
    .pop_data   (tx_head),
    .level      (tx_level)
  );

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .push_valid (rx_push),
    .push_ready (rx_ready),
    .push_data  (rx_word),
    .pop_valid  (rx_valid),
    .pop_ready  (rx_pop),
    .pop_data   (rx_head),
    .level      (rx_level)
  );

  // ==========================================================================
  // Pin synchronisers and bit-rate divider.
  // Slave clock edges are seen two cycles late, hence the slow-clock limit.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'b000;
      {fss_s1, fss_s2, fss_s3}    <= 3'b111;
      {rxd_s1, rxd_s2}            <= 2'b00;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {serial_clock_in, sclk_s1, sclk_s2};
      {fss_s1, fss_s2, fss_s3}    <= {frame_select_in, fss_s1, fss_s2};
      {rxd_s1, rxd_s2}            <= {serial_receive_line, rxd_s1};
    end
  end

  assign half_pre  = (prescale_r[7:1] == 7'd0) ? 7'd1 : prescale_r[7:1];
  assign half_tick = en && (pre_cnt_r == half_pre - 7'd1) && (scr_cnt_r == ctrl0_r[15:8]);
  assign tick      = slave ? (sclk_s2 ^ sclk_s3) : half_tick;

  always_comb begin
    pre_cnt_nxt = '0;
    scr_cnt_nxt = '0;
    if (en && !half_tick) begin
      pre_cnt_nxt = (pre_cnt_r >= half_pre - 7'd1) ? 7'd0 : pre_cnt_r + 7'd1;
      scr_cnt_nxt = (pre_cnt_r >= half_pre - 7'd1) ? scr_cnt_r + 8'd1 : scr_cnt_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_cnt_r <= '0;
      scr_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      scr_cnt_r <= scr_cnt_nxt;
    end
  end

  // ==========================================================================
  // Frame engine.
  assign rxd_in   = loopback ? txd_r : rxd_s2;
  assign slv_ssf  = slave & (fmt == FMT_SSF);
  assign slv_go   = (fmt == FMT_SSF) ? (fss_s3 & ~fss_s2) : ((ph1 | fmt == FMT_CR) ? ~fss_s2 : (fss_s3 & ~fss_s2));
  assign go       = en & (slave ? slv_go : tx_valid);
  assign fss_lost = slave & (fmt != FMT_SSF) & fss_s2;
  assign edge_inc = edge_r + 6'd1;
  assign ror_evt  = rx_push & ~rx_ready;
  assign rt_evt   = half_tick & (rt_cnt_r == `RT_HALF_TICKS - 7'd1);

  always_comb begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    rx_sh_nxt = rx_sh_r;
    edge_nxt  = edge_r;
    sclk_nxt  = sclk_r;
    fss_nxt   = fss_r;
    txd_nxt   = txd_r;
    lead_nxt  = lead_r;
    load      = 1'b0;
    rx_push   = 1'b0;
    case (st_r)
      ST_IDLE: begin
        sclk_nxt = 1'b0;
        fss_nxt  = (fmt != FMT_SSF);
        if (go) begin
          load     = 1'b1;
          edge_nxt = slv_ssf ? 6'd1 : 6'd0;
          sclk_nxt = slv_ssf;
          sh_nxt   = sh_load;
          if (!ph1 || slv_ssf) begin
            txd_nxt = sh_load[15];
            sh_nxt  = {sh_load[14:0], 1'b0};
          end
          if (slave) begin
            st_nxt = ST_SHIFT;
          end else begin
            st_nxt   = ST_LEAD;
            fss_nxt  = (fmt == FMT_SSF);
            lead_nxt = (fmt == FMT_SSF) ? `LEAD_SSF : `LEAD_SPI;
          end
        end
      end
      ST_LEAD: begin
        if (tick) begin
          lead_nxt = lead_r - 2'd1;
          if (lead_r == 2'd1) begin
            st_nxt  = ST_SHIFT;
            fss_nxt = (fmt != FMT_SSF) ? 1'b0 : 1'b0;
          end
        end
      end
      ST_SHIFT: begin
        if (fss_lost) begin
          st_nxt = ST_IDLE;
        end else if (tick) begin
          sclk_nxt = ~sclk_r;
          edge_nxt = edge_inc;
          if (edge_inc[0] ^ ph1) begin
            rx_sh_nxt = {rx_sh_r[14:0], rxd_in};
          end else if (edge_inc != edges_tot) begin
            txd_nxt = sh_r[15];
            sh_nxt  = {sh_r[14:0], 1'b0};
          end
          if (edge_inc == edges_tot) begin
            rx_push = 1'b1;
            st_nxt  = slave ? ST_IDLE : ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        if (tick) begin
          st_nxt  = ST_IDLE;
          // Select returns to idle here, so back-to-back words still see a select pulse.
          fss_nxt = (fmt != FMT_SSF);
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!en) begin
      st_nxt = ST_IDLE;
    end
    rt_cnt_nxt = '0;
    if (en && st_r == ST_IDLE && rx_valid && !rx_pop) begin
      rt_cnt_nxt = (half_tick && rt_cnt_r != `RT_HALF_TICKS - 7'd1) ? rt_cnt_r + 7'd1 : rt_cnt_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r     <= ST_IDLE;
      sh_r     <= '0;
      rx_sh_r  <= '0;
      edge_r   <= '0;
      sclk_r   <= 1'b0;
      fss_r    <= 1'b1;
      txd_r    <= 1'b0;
      lead_r   <= '0;
      rt_cnt_r <= '0;
    end else begin
      st_r     <= st_nxt;
      sh_r     <= sh_nxt;
      rx_sh_r  <= rx_sh_nxt;
      edge_r   <= edge_nxt;
      sclk_r   <= sclk_nxt;
      fss_r    <= fss_nxt;
      txd_r    <= txd_nxt;
      lead_r   <= lead_nxt;
      rt_cnt_r <= rt_cnt_nxt;
    end
  end

  assign serial_clock_out     = sclk_r ^ cpol;
  assign serial_clock_oe      = en & ~slave;
  assign frame_select_out     = fss_r;
  assign frame_select_oe      = en & ~slave;
  assign serial_transmit_line = txd_r;
  assign serial_transmit_oe   = (st_r != ST_IDLE) & ~loopback;

  // ==========================================================================
  // Checks.
  logic [15:0] gap_r;
  logic        gap_ok_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || half_tick) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 16'd1;
    end
    gap_ok_r <= !sys_rst && (half_tick || gap_ok_r) && !(wr_en && address != `OFS_DATA);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_tx_push;
    tx_push && tx_ready && !load |=> tx_level == $past(tx_level) + LW'(1);
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("data write did not enter transmit FIFO");
  property p_rx_pop;
    rx_pop && !rx_push |=> rx_level == $past(rx_level) - LW'(1);
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("data read did not pop receive FIFO");
  property p_div;
    half_tick && gap_ok_r && !slave |-> (gap_r + 16'd1) == 16'(half_pre) * (16'(ctrl0_r[15:8]) + 16'd1);
  endproperty
  a_div: assert property (p_div) else $error("half bit period differs from divider setting");
  property p_irq_or;
    ##1 irq == |($past(ris) & $past(imask_r));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("combined interrupt is not OR of enabled sources");
  property p_mask;
    !imask_r[`INT_TX] |=> !irq_tx;
  endproperty
  a_mask: assert property (p_mask) else $error("masked transmit interrupt reached output");
  property p_overrun;
    rx_push && !rx_ready |=> ris[`INT_ROR] && rx_level == $past(rx_level);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged or word stored");
  property p_timeout;
    rt_evt |=> ris[`INT_RT] ##1 irq_timeout == $past(imask_r[`INT_RT]);
  endproperty
  a_timeout: assert property (p_timeout) else $error("receive timeout not raised");
  property p_msb_first;
    st_r == ST_SHIFT && tick && !fss_lost && !(edge_inc[0] ^ ph1) && edge_inc != edges_tot
      |=> serial_transmit_line == $past(sh_r[15]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit not launched from shifter top");
  property p_loop;
    loopback && st_r == ST_SHIFT && tick && !fss_lost && (edge_inc[0] ^ ph1) |=> rx_sh_r[0] == $past(txd_r);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback did not capture transmitted bit");
  property p_slave_pads;
    slave |-> !serial_clock_oe && !frame_select_oe;
  endproperty
  a_slave_pads: assert property (p_slave_pads) else $error("slave drives clock or frame pad");

  c_frame: cover property (st_r == ST_SHIFT ##1 st_r == ST_TAIL);
  c_overrun: cover property (ror_evt);
  c_timeout: cover property (rt_evt);
  c_loop_frame: cover property (loopback && rx_push);
endmodule

// >>> ssp_defs.svh
`ifndef SSP_CORE_DEFS_SVH
`define SSP_CORE_DEFS_SVH
// Behaviour
// - Port runs as serial master driving the clock, or slave following one.
// - Data port write pushes a word into a 16-bit by 8-entry transmit FIFO.
// - Received words go to a 16-bit by 8-entry FIFO; data read pops oldest.
// - Frame length programmable from 4 to 16 bits per word.
// - System clock first divided by an even prescale divisor from 2 to 254.
// - Prescaled clock further divided by one plus the serial clock rate field.
// - Serial clock equals system clock over prescale times one plus rate.
// - Four conditions: transmit service, receive service, receive timeout, overrun.
// - All enabled conditions are ORed onto one interrupt request line.
// - Each condition has a mask bit; one lets it reach the interrupt output.
// - Individual per-condition interrupt outputs exist beside the combined one.
// - Raw and masked condition states readable through two status registers.
// - Loopback test mode routes transmitted serial data back to the receiver.
// - Three frame formats: four-wire SPI, frame-pulse serial, half-duplex command.
// - Received serial data is shifted into a register before loading the FIFO.
// - Every word is shifted out most significant bit first.
// - Timeout raised when serial clock idles a timeout period with data held.

// ==========================================================================
// Register byte offsets.
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_DATA       8'h08
`define OFS_STATUS     8'h0c
`define OFS_PRESCALE   8'h10
`define OFS_IMASK      8'h14
`define OFS_RIS        8'h18
`define OFS_MIS        8'h1c
`define OFS_ICLR       8'h20

// ==========================================================================
// Field positions and reset values.
`define C0_CPOL        6
`define C0_CPHA        7
`define C1_LOOP        0
`define C1_EN          1
`define C1_SLAVE       2
`define INT_TX         0
`define INT_RX         1
`define INT_RT         2
`define INT_ROR        3
`define CTRL0_RST      16'h0007
`define PRESCALE_RST   8'h02

// ==========================================================================
// Frame timing counts.
`define MIN_BITS       5'd4
`define CR_EXTRA_BITS  6'd9
`define LEAD_SPI       2'd1
`define LEAD_SSF       2'd2
`define RT_HALF_TICKS  7'd64
`endif

// >>> ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [1:0] {FMT_SPI, FMT_SSF, FMT_CR, FMT_RSV} frame_fmt_t;
  typedef enum {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL} eng_state_t;
endpackage

// >>> ssp_peer.sv
`timescale 1ns/1ns
// ==========================================================================
// Serial peripheral on the far side: four-wire format, clock idle low, capture on rise.
module ssp_peer #(
  parameter int BITS = 8
) (
  // Pins from the port
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  output logic             miso,
  // Reply word and captured word
  input  wire logic [15:0] reply,
  output logic [15:0]      got
);
  logic [15:0] sh;
  initial begin
    miso = 1'b0;
    got  = 16'h0;
  end
  always @(negedge sel_n) begin
    got  = 16'h0;
    sh   = reply;
    miso = reply[BITS-1];
  end
  always @(negedge sclk) begin
    if (sel_n === 1'b0) begin
      sh   = sh << 1;
      miso = sh[BITS-1];
    end
  end
  always @(posedge sclk) begin
    if (sel_n === 1'b0) begin
      got = {got[14:0], mosi};
    end
  end
  // A released line shows no stale value, so it flips instead of holding.
  always @(posedge sel_n) begin
    miso = ~miso;
  end
endmodule

// >>> test_sync_serial_port_core.sv
`timescale 1ns/1ns
`include "ssp_defs.svh"
module test_sync_serial_port_core;
  import ssp_pkg::*;
  localparam int PRE = 4;
  localparam int RATE = 3;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, sck, sel_n, txd, miso, irq, irq_tx, irq_rx, irq_to, irq_or;
  logic sck_oe, fs_oe;
  logic sc_in = 1'b0;
  logic fs_in = 1'b1;
  logic [15:0] reply = 16'h0;
  logic [15:0] got;
  logic [31:0] rq[$];
  logic [31:0] sq[$];
  logic [31:0] d[9];
  int num_errors = 0;
  int samples_checked = 0;
  time t_rise = 0;
  always #20 clk_sys = ~clk_sys;
  ssp_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .serial_clock_out(sck), .serial_clock_oe(sck_oe), .serial_clock_in(sc_in), .frame_select_out(sel_n),
    .frame_select_oe(fs_oe), .frame_select_in(fs_in), .serial_transmit_line(txd), .serial_transmit_oe(),
    .serial_receive_line(miso), .irq(irq), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_timeout(irq_to),
    .irq_overrun(irq_or));
  ssp_peer #(.BITS(8)) peer (.sclk(sck), .sel_n(sel_n), .mosi(txd), .miso(miso), .reply(reply), .got(got));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (e !== s) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then lets one edge pass.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] v);
    address   <= a;
    write     <= wr;
    read      <= !wr;
    writedata <= v;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic idle();
    do bus(`OFS_STATUS, 1'b0, 32'h0); while (readdata[4] !== 1'b0 || readdata[0] !== 1'b1);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchers: bus reads, peer words and serial clock period.
  always @(posedge clk_sys) begin
    if (read === 1'b1 && waitrequest === 1'b0 && rq.size() > 0) begin
      chk("readdata", rq.pop_front(), readdata);
    end
  end
  always @(posedge sel_n) begin
    if (sq.size() > 0) begin
      chk("peer_word", sq.pop_front(), {16'h0, got});
    end
    t_rise = 0;
  end
  always @(posedge sck) begin
    if (sel_n === 1'b0 && t_rise != 0) begin
      chk("sclk_period", 40 * PRE * (RATE + 1), $time - t_rise);
    end
    t_rise = (sel_n === 1'b0) ? $time : 0;
  end
  initial begin
    #(40 * 30000);
    num_errors++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hc6a6602a));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(`OFS_CTRL0, 32'h7);
    rd(`OFS_PRESCALE, 32'h2);
    rd(8'h40, 32'h0);
    bus(`OFS_PRESCALE, 1'b1, 32'h5);
    rd(`OFS_PRESCALE, 32'h4);
    bus(`OFS_CTRL0, 1'b1, {16'h0, 8'(RATE), 8'h07});
    $display("test registers done");
    bus(`OFS_IMASK, 1'b1, 32'h2);
    bus(`OFS_CTRL1, 1'b1, 32'h3);
    for (int i = 0; i < 4; i++) begin
      d[i] = $urandom & 32'hff;
      bus(`OFS_DATA, 1'b1, d[i]);
    end
    idle();
    rd(`OFS_RIS, 32'h3);
    rd(`OFS_MIS, 32'h2);
    chk("irq_rx", 1'b1, irq_rx);
    chk("irq", 1'b1, irq);
    chk("irq_tx", 1'b0, irq_tx);
    for (int i = 0; i < 4; i++) rd(`OFS_DATA, d[i]);
    repeat (2) @(posedge clk_sys);
    chk("irq_clear", 1'b0, irq);
    $display("test loopback done");
    bus(`OFS_CTRL0, 1'b1, {16'h0, 8'(RATE), 8'h13});
    d[4] = $urandom & 32'hf;
    bus(`OFS_DATA, 1'b1, d[4]);
    idle();
    rd(`OFS_DATA, d[4]);
    bus(`OFS_CTRL0, 1'b1, {16'h0, 8'(RATE), 8'h07});
    $display("test frame pulse done");
    bus(`OFS_CTRL1, 1'b1, 32'h2);
    chk("master_oe", 32'h3, {sck_oe, fs_oe});
    for (int i = 0; i < 3; i++) begin
      d[0] = $urandom & 32'hff;
      reply <= 16'($urandom & 32'hff);
      @(posedge clk_sys);
      sq.push_back(d[0]);
      bus(`OFS_DATA, 1'b1, d[0]);
      idle();
      rd(`OFS_DATA, {16'h0, reply});
    end
    $display("test master done");
    bus(`OFS_IMASK, 1'b1, 32'h8);
    bus(`OFS_CTRL1, 1'b1, 32'h3);
    for (int i = 0; i < 9; i++) begin
      d[i] = $urandom & 32'hff;
      bus(`OFS_DATA, 1'b1, d[i]);
      if (i == 7) idle();
    end
    idle();
    chk("irq_overrun", 1'b1, irq_or);
    repeat (600) @(posedge clk_sys);
    rd(`OFS_RIS, 32'hf);
    bus(`OFS_IMASK, 1'b1, 32'hc);
    repeat (2) @(posedge clk_sys);
    chk("irq_timeout", 1'b1, irq_to);
    for (int i = 0; i < 8; i++) rd(`OFS_DATA, d[i]);
    bus(`OFS_ICLR, 1'b1, 32'hc);
    repeat (2) @(posedge clk_sys);
    chk("overrun_clear", 1'b0, irq_or);
    chk("timeout_clear", 1'b0, irq_to);
    $display("test overrun done");
    bus(`OFS_CTRL1, 1'b1, 32'h7);
    chk("slave_oe", 32'h0, {sck_oe, fs_oe});
    d[0] = $urandom & 32'hff;
    bus(`OFS_DATA, 1'b1, d[0]);
    fs_in <= 1'b0;
    repeat (12) @(posedge clk_sys);
    repeat (16) begin
      sc_in <= ~sc_in;
      repeat (12) @(posedge clk_sys);
    end
    fs_in <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rd(`OFS_DATA, d[0]);
    $display("test slave done");
    end_of_test();
  end
endmodule
